// ==== sswd_core.sv ====
// Function
// - Manual restart low asserts reset and holds it while low.
// - Reset low when supply under threshold or manual low; each pulse lasts stretch.
// - Reset held a further 200ms after supply recovers or manual rises.
// - Active-high reset always the inverse of active-low reset.
// - Watchdog fault goes low when kick stays constant past the timeout.
// - Watchdog fault returns high on next kick edge of either polarity.
// - Fault high between switchover and restart threshold, low below switchover.
// - Gated chip-select low only when raw select low and either reset inactive or the hold at reset entry running.
// - Select low at reset assertion stays low 10us or until raw goes high.
// - Backup cell good follows cell comparator in normal operation, continuously.
// - Below switchover, cell good evaluation disabled and output forced low.
// - Power fail flag low on sense under threshold or supply under switchover.
// - Cell selected below switchover and cell; main back above restart or cell.
// - Cell selected output high on cell, low on main supply.
// - Early supply warning low once supply falls to the low-line threshold.
// - Watchdog timeout nominal 1.6s; timer restarts at each kick edge.
// - Watchdog timer cleared and idle during reset, counts after release.
// - First half of stretch ignores manual restart while flag forced low.
`timescale 1ns/1ps
`default_nettype none
`include "sswd_params.svh"
module sswd_core
  import sswd_pkg::*;
#(
  parameter int unsigned STRETCH_CYC = 32'(`SSWD_STRETCH_CYC),
  parameter int unsigned CE_HOLD_CYC = 32'(`SSWD_CE_HOLD_CYC),
  parameter int unsigned WD_CYC      = 32'(`SSWD_WD_CYC)
) (
  // Clock, reset, enable
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Comparator results
  input  wire logic supply_above_restart,
  input  wire logic supply_above_switchover,
  input  wire logic supply_above_cell,
  input  wire logic cell_above_good,
  input  wire logic power_fail_sense,
  input  wire logic supply_above_early,
  // Host side pins
  input  wire logic manual_restart_n,
  input  wire logic watchdog_kick,
  input  wire logic chip_sel_in_n,
  input  wire logic power_fail_flag_in,
  // Outputs
  output var  logic reset_n,
  output var  logic reset_hi,
  output var  logic watchdog_fault_n,
  output var  logic chip_sel_out_n,
  output var  logic backup_cell_good,
  output var  logic power_fail_flag_n,
  output var  logic power_fail_flag_oe,
  output var  logic backup_cell_selected,
  output var  logic early_supply_warning
);
  typedef struct packed {
    sswd_rst_state_t st;
    logic [31:0]     stretch;
    logic [31:0]     wd;
    logic [31:0]     ce_cnt;
    logic            ce_hold;
    logic            kick_q;
    logic            on_cell;
    logic            reset_n;
    logic            reset_hi;
    logic            wdo_n;
    logic            cs_n;
    logic            good;
    logic            pfo_n;
    logic            pfo_oe;
    logic            early;
  } sswd_state_t;

  sswd_state_t r, next_r;
  sswd_in_t    raw, s;
  logic        rst_req, kick_edge;

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  assign raw = '{supply_ok: supply_above_restart, above_switch: supply_above_switchover,
                 supply_gt_cell: supply_above_cell, cell_good: cell_above_good,
                 pf_ok: power_fail_sense, early_ok: supply_above_early,
                 mr_n: manual_restart_n, kick: watchdog_kick, ce_in_n: chip_sel_in_n,
                 pfo_forced_low: ~power_fail_flag_in};
  sswd_sync #(.W($bits(sswd_in_t))) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ce      (clk_en),
    .d       (raw),
    .q       (s)
  );

  // Flag counts as forced only when the pin is low while we release it
  function automatic logic mr_ignored(input sswd_state_t x, input logic forced, input logic drv_hi);
    mr_ignored = (x.st == SSWD_STRETCH) && (x.stretch < STRETCH_CYC / 2) && forced && drv_hi;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_r    = r;
    kick_edge = s.kick ^ r.kick_q;
    next_r.kick_q = s.kick;
    // Manual restart is masked early in the stretch for the seal sequence
    rst_req = ~s.supply_ok |
              (~s.mr_n & ~mr_ignored(r, s.pfo_forced_low, r.pfo_n));
    unique case (r.st)
      SSWD_HOLD: begin
        next_r.stretch = 32'h0;
        if (!rst_req) begin
          next_r.st = SSWD_STRETCH;
        end
      end
      SSWD_STRETCH: begin
        if (rst_req) begin
          next_r.st = SSWD_HOLD;  // Brownout restarts the timer
        end else if (r.stretch >= STRETCH_CYC - 1) begin
          next_r.st = SSWD_RUN;
        end else begin
          next_r.stretch = r.stretch + 32'h1;
        end
      end
      SSWD_RUN: begin
        if (rst_req) begin
          next_r.st = SSWD_HOLD;
        end
      end
    endcase
    next_r.reset_n  = (next_r.st == SSWD_RUN);
    next_r.reset_hi = ~next_r.reset_n;
    // Watchdog: cleared under reset, restarted by any kick edge
    if (!next_r.reset_n || kick_edge) begin
      next_r.wd = 32'h0;
    end else if (r.wd < WD_CYC) begin
      next_r.wd = r.wd + 32'h1;
    end
    if (!s.above_switch) begin
      next_r.wdo_n = 1'b0;
    end else if (!next_r.reset_n || kick_edge) begin
      next_r.wdo_n = 1'b1;
    end else if (r.wd >= WD_CYC - 1) begin
      next_r.wdo_n = 1'b0;
    end
    // Chip-select gating with short grace at reset entry
    if (r.reset_n && !next_r.reset_n && !s.ce_in_n) begin
      next_r.ce_hold = 1'b1;
      next_r.ce_cnt  = 32'h0;
    end else if (r.ce_hold) begin
      next_r.ce_cnt  = r.ce_cnt + 32'h1;
      next_r.ce_hold = ~s.ce_in_n && (r.ce_cnt < CE_HOLD_CYC - 1);
    end
    next_r.cs_n = ~(~s.ce_in_n && (next_r.reset_n || next_r.ce_hold));
    next_r.good = s.above_switch & s.cell_good;
    next_r.pfo_n = s.pf_ok & s.above_switch;
    next_r.pfo_oe = ~next_r.pfo_n;               // Registered so the pin comes from a flop
    // Switchover with hysteresis
    if (!s.above_switch && !s.supply_gt_cell) begin
      next_r.on_cell = 1'b1;
    end else if (s.supply_ok || s.supply_gt_cell) begin
      next_r.on_cell = 1'b0;
    end
    next_r.early = s.early_ok;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r          <= '0;
      r.st       <= SSWD_HOLD;
      r.reset_n  <= `SSWD_RST_RESET_N;
      r.reset_hi <= 1'b1;
      r.pfo_n    <= `SSWD_RST_FLAG_N;
      r.pfo_oe   <= ~`SSWD_RST_FLAG_N;
      r.cs_n     <= `SSWD_RST_SELECT_N;  // Select blocked while reset is held
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign reset_n              = r.reset_n;
  assign reset_hi             = r.reset_hi;
  assign watchdog_fault_n     = r.wdo_n;
  assign chip_sel_out_n       = r.cs_n;
  assign backup_cell_good     = r.good;
  assign power_fail_flag_n    = r.pfo_n;
  assign power_fail_flag_oe   = r.pfo_oe;  // Open drain: high only while pulling low
  assign backup_cell_selected = r.on_cell;
  assign early_supply_warning = r.early;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_reset_inverse: assert property (reset_hi == ~reset_n)
    else $error("active-high reset not inverse");
  a_mr_holds_reset: assert property (clk_en && !s.mr_n && s.pfo_forced_low == 1'b0 ##1 clk_en |-> !reset_n)
    else $error("reset released while manual restart low");
  a_stretch_min: assert property ($rose(r.st == SSWD_STRETCH) |-> r.stretch == 0)
    else $error("stretch counter not cleared");
  a_release_count: assert property ($rose(reset_n) |-> $past(r.stretch) == STRETCH_CYC - 1)
    else $error("reset released early");
  a_wd_cleared: assert property (!reset_n |-> r.wd == 0)
    else $error("watchdog counting in reset");
  a_wdo_low_switch: assert property (clk_en && !s.above_switch |=> !watchdog_fault_n)
    else $error("fault not low below switchover");
  a_wdo_kick_high: assert property (clk_en && kick_edge && s.above_switch |=> watchdog_fault_n)
    else $error("fault not cleared by kick");
  a_cs_gating: assert property (!chip_sel_out_n |-> r.reset_n || r.ce_hold)
    else $error("chip select passed during reset");
  a_good_forced: assert property (clk_en && !s.above_switch |=> !backup_cell_good)
    else $error("cell good not forced low");
  c_reset_release: cover property ($rose(reset_n));
  c_wd_fault: cover property ($fell(watchdog_fault_n) && reset_n);
  c_cs_hold: cover property ($fell(r.ce_hold));
  c_on_cell: cover property ($rose(backup_cell_selected));
endmodule // sswd_core
`default_nettype wire

// ==== sswd_params.svh ====
`ifndef SSWD_PARAMS_SVH
`define SSWD_PARAMS_SVH
// ------------------------------------------------------------
// Timing figures
// ------------------------------------------------------------
`define SSWD_CLK_PERIOD_PS 64'd5000
`define SSWD_STRETCH_MS    64'd200
`define SSWD_CE_HOLD_NS    64'd10000
`define SSWD_WD_TIMEOUT_MS 64'd1600
// Least times round up, the timeout is nominal and rounds down
`define SSWD_STRETCH_CYC ((`SSWD_STRETCH_MS * 64'd1000000000 + `SSWD_CLK_PERIOD_PS - 64'd1) / `SSWD_CLK_PERIOD_PS)
`define SSWD_CE_HOLD_CYC ((`SSWD_CE_HOLD_NS * 64'd1000 + `SSWD_CLK_PERIOD_PS - 64'd1) / `SSWD_CLK_PERIOD_PS)
`define SSWD_WD_CYC      ((`SSWD_WD_TIMEOUT_MS * 64'd1000000000) / `SSWD_CLK_PERIOD_PS)
// Reset values of the outputs
`define SSWD_RST_RESET_N 1'b0
`define SSWD_RST_FLAG_N  1'b0
`define SSWD_RST_SELECT_N 1'b1
`endif

// ==== sswd_pkg.sv ====
package sswd_pkg;
  // Synchronised comparator and pin levels
  typedef struct packed {
    logic supply_ok;
    logic above_switch;
    logic supply_gt_cell;
    logic cell_good;
    logic pf_ok;
    logic early_ok;
    logic mr_n;
    logic kick;
    logic ce_in_n;
    logic pfo_forced_low;
  } sswd_in_t;
  typedef enum logic [1:0] {SSWD_HOLD, SSWD_STRETCH, SSWD_RUN} sswd_rst_state_t;
endpackage

// ==== sswd_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sswd_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;
  // ------------------------------------------------------------
  // Two-stage synchroniser, one per bit
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          meta[i] <= 1'b0;
          q[i]    <= 1'b0;
        end else if (ce) begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule // sswd_sync
`default_nettype wire

// ==== sswd_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sswd_host (
  // Clock
  input  wire logic sys_clk,
  // Bench controls
  input  wire logic kick_en,
  input  wire logic route_fault,
  input  wire logic man_n,
  input  wire logic force_low,
  // Device pins
  input  wire logic watchdog_fault_n,
  input  wire logic power_fail_flag_oe,
  output var  logic watchdog_kick,
  output var  logic manual_restart_n,
  output var  logic power_fail_flag_in
);
  logic [2:0] cnt = 3'h0;
  // Kick every 8 cycles, far inside the timeout
  initial watchdog_kick = 1'b0;
  always @(posedge sys_clk) begin
    cnt <= cnt + 3'h1;
    if (kick_en && cnt == 3'h7) watchdog_kick <= #1 ~watchdog_kick;
  end
  // Fault diode-ORed into restart when routed
  assign manual_restart_n = man_n & (~route_fault | watchdog_fault_n);
  // Open-drain flag wire, pulled up
  assign power_fail_flag_in = ~(power_fail_flag_oe | force_low);
endmodule // sswd_host
`default_nettype wire

// ==== sswd_core_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module sswd_core_bench;
  logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
  logic supply_above_restart, supply_above_switchover, supply_above_cell;
  logic cell_above_good, power_fail_sense, supply_above_early, chip_sel_in_n;
  logic kick_en, route_fault, man_n, force_low;
  logic watchdog_kick, manual_restart_n, power_fail_flag_in;
  logic reset_n, reset_hi, watchdog_fault_n, chip_sel_out_n, backup_cell_good;
  logic power_fail_flag_n, power_fail_flag_oe, backup_cell_selected, early_supply_warning;
  int   n_errors = 0, samples_checked = 0;
  // Rows: six comparator levels, then good, flag, selected, early, fault
  logic [10:0] tbl [6] = '{11'h7FB, 11'h701, 11'h3FB, 11'h0E6, 11'h2FF, 11'h6FB};

  // Short counts keep the run brief
  sswd_core #(.STRETCH_CYC(20), .CE_HOLD_CYC(5), .WD_CYC(50)) dut (.sys_clk, .rstn, .clk_en,
    .supply_above_restart, .supply_above_switchover, .supply_above_cell, .cell_above_good,
    .power_fail_sense, .supply_above_early, .manual_restart_n, .watchdog_kick, .chip_sel_in_n,
    .power_fail_flag_in, .reset_n, .reset_hi, .watchdog_fault_n, .chip_sel_out_n,
    .backup_cell_good, .power_fail_flag_n, .power_fail_flag_oe, .backup_cell_selected,
    .early_supply_warning);
  sswd_host host (.sys_clk, .kick_en, .route_fault, .man_n, .force_low, .watchdog_fault_n,
    .power_fail_flag_oe, .watchdog_kick, .manual_restart_n, .power_fail_flag_in);

  always #2.5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounded wait: sel 0 watches reset_n, 1 the fault
  task automatic wait_bit(input int sel, input logic v, input int n);
    int i;
    for (i = 0; i < n && (sel ? watchdog_fault_n : reset_n) !== v; i++) step(1);
    chk(sel ? "watchdog_fault_n" : "reset_n", v, sel ? watchdog_fault_n : reset_n);
    // Only a bound that really ran out ends the run early
    if ((sel ? watchdog_fault_n : reset_n) !== v) finish_test();
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {supply_above_restart, supply_above_switchover, supply_above_cell} = 3'h7;
    {cell_above_good, power_fail_sense, supply_above_early} = 3'h7;
    {chip_sel_in_n, kick_en, route_fault, man_n, force_low} = 5'h1A;
    step(2);
    rstn = 1'b1;
    step(18);
    chk("reset_n", 1'b0, reset_n);
    wait_bit(0, 1'b1, 8);
    // Manual restart held, then stretched
    man_n = 1'b0;
    step(4);
    chk("reset_n", 1'b0, reset_n);
    chk("reset_hi", 1'b1, reset_hi);
    step(40);
    chk("reset_n", 1'b0, reset_n);
    man_n = 1'b1;
    step(20);
    chk("reset_n", 1'b0, reset_n);
    wait_bit(0, 1'b1, 6);
    // Early restart pulse ignored while flag wire forced low
    man_n = 1'b0;
    step(4);
    man_n = 1'b1;
    force_low = 1'b1;
    step(4);
    man_n = 1'b0;
    step(3);
    man_n = 1'b1;
    step(14);
    wait_bit(0, 1'b1, 4);
    force_low = 1'b0;
    // Gated select, then its hold past reset assertion
    chip_sel_in_n = 1'b0;
    step(4);
    chk("chip_sel_out_n", 1'b0, chip_sel_out_n);
    man_n = 1'b0;
    step(5);
    chk("chip_sel_out_n", 1'b0, chip_sel_out_n);
    step(5);
    chk("chip_sel_out_n", 1'b1, chip_sel_out_n);
    {chip_sel_in_n, man_n} = 2'h3;
    wait_bit(0, 1'b1, 30);
    // Watchdog: regular kicks, starvation, recovery
    step(200);
    chk("watchdog_fault_n", 1'b1, watchdog_fault_n);
    kick_en = 1'b0;
    step(40);
    chk("watchdog_fault_n", 1'b1, watchdog_fault_n);
    wait_bit(1, 1'b0, 20);
    kick_en = 1'b1;
    wait_bit(1, 1'b1, 12);
    {route_fault, kick_en} = 2'h2;
    wait_bit(1, 1'b0, 70);
    wait_bit(0, 1'b0, 6);
    {route_fault, kick_en} = 2'h1;
    wait_bit(0, 1'b1, 40);
    // Supply flags over the comparator table
    for (int r = 0; r < 6; r++) begin
      {supply_above_restart, supply_above_switchover, supply_above_cell, cell_above_good,
        power_fail_sense, supply_above_early} = tbl[r][10:5];
      step(4);
      chk("backup_cell_good", tbl[r][4], backup_cell_good);
      chk("power_fail_flag_n", tbl[r][3], power_fail_flag_n);
      chk("power_fail_flag_oe", ~tbl[r][3], power_fail_flag_oe);
      chk("backup_cell_selected", tbl[r][2], backup_cell_selected);
      chk("early_supply_warning", tbl[r][1], early_supply_warning);
      chk("watchdog_fault_n", tbl[r][0], watchdog_fault_n);
      chk("reset_n", r < 2, reset_n);
      chk("reset_hi", r >= 2, reset_hi);
    end
    // Enable low freezes every stage, synchronisers included
    {clk_en, cell_above_good} = 2'h0;
    step(6);
    chk("backup_cell_good", 1'b1, backup_cell_good);
    clk_en = 1'b1;
    step(4);
    chk("backup_cell_good", 1'b0, backup_cell_good);
    finish_test();
  end
endmodule // sswd_core_bench
`default_nettype wire
